// ### common/osc_select_pkg.sv
// Constants for the oscillator select control block
// Overview of operation
// - Requested source code picks external, fast, slow, secondary or PLL clocks.
// - A reserved source code falls back to the fast internal oscillator.
// - Divider code n divides by two to the n, up to 512; 1010-1111 reserved.
// - Requested source loads the reset source fuse at reset.
// - Requested divider resets to 0010 for the 1 MHz source, else 0000.
// - Switch enable fuse cleared makes the request register read-only.
// - Read-only fields show the source and divider now in use.
// - Active fields equal the request fields after reset.
// - Switch hold pauses the switch once ready but still raises the interrupt.
// - Power select picks high or low power unless bypass is on.
// - Bypass makes the secondary input an external clock; else a crystal.
// - Switch complete reads 1 when request equals active, 0 while switching.
// - New source ready reads 1 only while pending and requested source ready.
// - Status register shows ready bits for each oscillator.
// - PLL ready reads 1 only when the PLL is enabled, fed and locked.
// - Unimplemented bits read zero and ignore writes.
// - Without hold, switch when new source ready sets; set sticky interrupt flag.
// - At the switch update active fields, set complete, clear new ready.
// - Sleep before the switch completes abandons the switch.
package osc_select_pkg;
  localparam int ADDR_W = 2;
  localparam logic [ADDR_W-1:0] ADDR_REQUEST = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_CURRENT = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 2'h2;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 2'h3;
  localparam int SRC_W = 3;
  localparam int DIV_W = 4;
  localparam int SRC_LSB = 4;
  localparam int HOLD_BIT = 7;
  localparam int PWR_BIT = 6;
  localparam int BYP_BIT = 5;
  localparam int DONE_BIT = 4;
  localparam int NRDY_BIT = 3;
  localparam int SEL_EXT = 7;
  localparam int SEL_FAST = 6;
  localparam int SEL_SLOW = 4;
  localparam int SEL_SEC = 3;
  localparam int SEL_EXT_PLL = 1;
  localparam int SEL_FAST_PLL = 0;
  localparam logic [SRC_W-1:0] SRC_EXT = 3'h7;
  localparam logic [SRC_W-1:0] SRC_FAST = 3'h6;
  localparam logic [SRC_W-1:0] SRC_RSVD_HI = 3'h5;
  localparam logic [SRC_W-1:0] SRC_SLOW = 3'h4;
  localparam logic [SRC_W-1:0] SRC_SEC = 3'h3;
  localparam logic [SRC_W-1:0] SRC_RSVD_LO = 3'h2;
  localparam logic [SRC_W-1:0] SRC_EXT_PLL = 3'h1;
  localparam logic [SRC_W-1:0] SRC_FAST_PLL = 3'h0;
  localparam logic [DIV_W-1:0] DIV_MAX = 4'h9;
  localparam logic [DIV_W-1:0] DIV_RST_FAST = 4'h2;
  localparam logic [DIV_W-1:0] DIV_RST_OTHER = 4'h0;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CTRL_WR_MASK = 8'hE0;
  localparam logic [7:0] STAT_MASK = 8'hDD;
endpackage

// ### hdl/oscillator_select_control.sv
// Oscillator source and postscaler selection with register port
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/100ps
module oscillator_select_control #(
  parameter int NUM_SRC = 8,
  parameter int MAX_DIV = 9
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [osc_select_pkg::ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic [osc_select_pkg::SRC_W-1:0] i_reset_source_fuse,
  input wire logic i_switch_enable_fuse,
  input wire logic i_sleep,
  input wire logic [NUM_SRC-1:0] i_src_clk,
  input wire logic i_external_ready,
  input wire logic i_fast_internal_ready,
  input wire logic i_slow_internal_ready,
  input wire logic i_secondary_ready,
  input wire logic i_converter_rc_ready,
  input wire logic i_pll_enabled,
  input wire logic i_pll_locked,
  output logic o_switch_interrupt_flag,
  input wire logic i_switch_interrupt_clear,
  output logic [osc_select_pkg::SRC_W-1:0] o_requested_source,
  output logic o_secondary_high_power,
  output logic o_secondary_bypass,
  output logic o_pll_input_ext,
  output logic o_sys_clk
);
  import osc_select_pkg::*;

  initial begin
    if (NUM_SRC != 8 || MAX_DIV < 1 || MAX_DIV > 15) begin
      $error("oscillator_select_control: unsupported parameters");
    end
  end

  logic [SRC_W-1:0] req_src_r;
  logic [DIV_W-1:0] req_div_r;
  logic [SRC_W-1:0] act_src_r;
  logic [DIV_W-1:0] act_div_r;
  logic hold_r;
  logic pwr_r;
  logic byp_r;
  logic irq_r;
  logic rdy_seen_r;
  logic [7:0] rdata_r;
  logic init_r;
  logic [6:0] fuse_init_r;

  // Fuse values caught by a clocked process during reset
  wire [DIV_W-1:0] fuse_div = (i_reset_source_fuse == SRC_FAST) ? DIV_RST_FAST : DIV_RST_OTHER;

  wire wr_req = i_wr && (i_addr == ADDR_REQUEST);
  wire wr_ctl = i_wr && (i_addr == ADDR_CONTROL);
  wire src_rsvd = (i_wdata[SRC_LSB +: SRC_W] == SRC_RSVD_HI) ||
                  (i_wdata[SRC_LSB +: SRC_W] == SRC_RSVD_LO);
  wire [SRC_W-1:0] wr_src = src_rsvd ? SRC_FAST : i_wdata[SRC_LSB +: SRC_W];
  // reserved divider codes
  // Reserved divider codes clamp to the largest ratio
  wire [DIV_W-1:0] wr_div = (i_wdata[DIV_W-1:0] > DIV_W'(MAX_DIV)) ? DIV_W'(MAX_DIV) :
                            i_wdata[DIV_W-1:0];

  wire pll_in_ready = (req_src_r == SRC_EXT_PLL) ? i_external_ready : i_fast_internal_ready;
  wire pll_ready = i_pll_enabled && i_pll_locked && pll_in_ready;

  logic src_ready;
  always_comb begin
    src_ready = 1'b0;
    unique case (req_src_r)
      SRC_EXT: src_ready = i_external_ready;
      SRC_FAST: src_ready = i_fast_internal_ready;
      SRC_SLOW: src_ready = i_slow_internal_ready;
      SRC_SEC: src_ready = i_secondary_ready;
      SRC_EXT_PLL: src_ready = pll_ready;
      SRC_FAST_PLL: src_ready = pll_ready;
      default: src_ready = 1'b0;
    endcase
  end

  wire pending = (req_src_r != act_src_r) || (req_div_r != act_div_r);
  wire new_ready = pending && src_ready;
  wire do_switch = new_ready && !hold_r && !i_sleep;
  wire abandon = pending && i_sleep;
  wire rdy_rise = new_ready && !rdy_seen_r;

  wire [7:0] reg_req = {1'b0, req_src_r, req_div_r};
  wire [7:0] reg_cur = {1'b0, act_src_r, act_div_r};
  wire [7:0] reg_ctl = {hold_r, pwr_r, byp_r, !pending, new_ready, 3'h0};
  wire [7:0] reg_stat = {i_external_ready, i_fast_internal_ready, 1'b0,
                         i_slow_internal_ready, i_secondary_ready,
                         i_converter_rc_ready, 1'b0, pll_ready} & STAT_MASK;
  wire [7:0] rd_mux = (i_addr == ADDR_REQUEST) ? reg_req :
                      (i_addr == ADDR_CURRENT) ? reg_cur :
                      (i_addr == ADDR_CONTROL) ? reg_ctl : reg_stat;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      init_r <= 1'b1;
      fuse_init_r <= {i_reset_source_fuse, fuse_div};
    end else begin
      init_r <= 1'b0;
      fuse_init_r <= fuse_init_r;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || init_r) begin
      req_src_r <= init_r ? fuse_init_r[DIV_W +: SRC_W] : i_reset_source_fuse;
      req_div_r <= init_r ? fuse_init_r[DIV_W-1:0] : fuse_div;
      act_src_r <= init_r ? fuse_init_r[DIV_W +: SRC_W] : i_reset_source_fuse;
      act_div_r <= init_r ? fuse_init_r[DIV_W-1:0] : fuse_div;
    end else begin
      if (wr_req && i_switch_enable_fuse) begin
        req_src_r <= wr_src;
        req_div_r <= wr_div;
      end else if (abandon) begin
        req_src_r <= act_src_r;
        req_div_r <= act_div_r;
      end
      if (do_switch) begin
        act_src_r <= req_src_r;
        act_div_r <= req_div_r;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      hold_r <= CTRL_RST[HOLD_BIT];
      pwr_r <= CTRL_RST[PWR_BIT];
      byp_r <= CTRL_RST[BYP_BIT];
      irq_r <= 1'b0;
      rdy_seen_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      if (do_switch || abandon) begin
        hold_r <= 1'b0;
      end else if (wr_ctl) begin
        hold_r <= i_wdata[HOLD_BIT] & CTRL_WR_MASK[HOLD_BIT];
      end
      if (wr_ctl) begin
        pwr_r <= i_wdata[PWR_BIT];
        byp_r <= i_wdata[BYP_BIT];
      end
      rdy_seen_r <= new_ready;
      if (rdy_rise) begin
        irq_r <= 1'b1;
      end else if (i_switch_interrupt_clear) begin
        irq_r <= 1'b0;
      end
      rdata_r <= i_rd ? rd_mux : 8'h00;
    end
  end

  assign o_rdata = rdata_r;
  assign o_switch_interrupt_flag = irq_r;
  assign o_requested_source = req_src_r;
  assign o_secondary_high_power = pwr_r && !byp_r;
  assign o_secondary_bypass = byp_r;
  assign o_pll_input_ext = (act_src_r == SRC_EXT_PLL);

  // postscaler ripple divider, one stage per bit
  logic [MAX_DIV:0] stage;
  assign stage[0] = i_src_clk[act_src_r];
  genvar g;
  generate
    for (g = 0; g < MAX_DIV; g++) begin : g_div
      logic t_r;
      always_ff @(posedge stage[g]) begin
        if (!i_rst_n) begin
          t_r <= 1'b0;
        end else begin
          t_r <= !t_r;
        end
      end
      assign stage[g+1] = t_r;
    end
  endgenerate
  // Plain mux; true glitch-free cell belongs in the clock library
  assign o_sys_clk = stage[act_div_r];

  // Assertions
  // hold blocks switch
  chk_hold_blocks_switch: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (hold_r && new_ready && !init_r) |=> $stable(act_src_r))
    else $error("switch taken while held");

  chk_switch_updates: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (do_switch && !wr_req && !init_r) |=> (act_src_r == $past(req_src_r)) && !pending)
    else $error("active fields not updated");

  chk_fuse_lock: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (!i_switch_enable_fuse && !abandon && !init_r) |=> $stable(req_src_r))
    else $error("request changed while locked");

  chk_reserved_src: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (req_src_r != SRC_RSVD_HI) && (req_src_r != SRC_RSVD_LO))
    else $error("reserved source stored");

  chk_flag_sets: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    rdy_rise |=> irq_r)
    else $error("switch flag missed");

  chk_hold_clears: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (abandon && !wr_req && !init_r) |=> !hold_r && !pending)
    else $error("hold or pending left after abandon");

  chk_div_range: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    req_div_r <= DIV_MAX)
    else $error("reserved divider stored");

  chk_ready_pending: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    reg_ctl[NRDY_BIT] |-> !reg_ctl[DONE_BIT])
    else $error("ready and complete together");

  chk_div_clamp: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (wr_req && i_switch_enable_fuse && (i_wdata[DIV_W-1:0] > DIV_MAX) && !init_r)
    |=> req_div_r == DIV_MAX)
    else $error("divider not clamped");

  chk_reserved_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (wr_req && i_switch_enable_fuse && src_rsvd && !init_r) |=> req_src_r == SRC_FAST)
    else $error("reserved write not mapped");

  chk_write_lands: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (wr_req && i_switch_enable_fuse && !src_rsvd && !init_r)
    |=> req_src_r == $past(i_wdata[SRC_LSB +: SRC_W]))
    else $error("requested source lost");

  chk_reset_request: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    init_r |=> req_src_r == $past(fuse_init_r[DIV_W +: SRC_W]))
    else $error("request not from fuse");

  chk_reset_divider: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    init_r |=> req_div_r == (($past(fuse_init_r[DIV_W +: SRC_W]) == SRC_FAST) ?
                             DIV_RST_FAST : DIV_RST_OTHER))
    else $error("reset divider wrong");

  chk_reset_active: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    init_r |=> (act_src_r == req_src_r) && (act_div_r == req_div_r))
    else $error("active differs after reset");

  chk_locked_divider: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (!i_switch_enable_fuse && !abandon && !init_r) |=> $stable(req_div_r))
    else $error("divider changed while locked");

  chk_no_switch_unready: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (!src_ready && !init_r) |=> $stable(act_src_r) && $stable(act_div_r))
    else $error("switch to unready source");

  chk_flag_sticky: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (irq_r && !i_switch_interrupt_clear) |=> irq_r)
    else $error("flag cleared by hardware");

  chk_flag_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_switch_interrupt_clear && !rdy_rise) |=> !irq_r)
    else $error("flag not cleared");

  chk_flag_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (!irq_r && !rdy_rise) |=> !irq_r)
    else $error("flag set without ready");

  chk_sleep_no_switch: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_sleep && !init_r) |=> $stable(act_src_r) && $stable(act_div_r))
    else $error("switch taken in sleep");

  chk_hold_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (wr_ctl && !do_switch && !abandon) |=> hold_r == $past(i_wdata[HOLD_BIT]))
    else $error("hold write lost");

  chk_power_mode: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    byp_r |-> !o_secondary_high_power)
    else $error("power mode in bypass");

  chk_power_follow: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (wr_ctl && !i_wdata[BYP_BIT]) |=> o_secondary_high_power == $past(i_wdata[PWR_BIT]))
    else $error("power mode lost");

  chk_bypass_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    wr_ctl |=> o_secondary_bypass == $past(i_wdata[BYP_BIT]))
    else $error("bypass write lost");

  chk_status_mask: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    ((reg_stat & ~STAT_MASK) == 8'h00) && !reg_req[SRC_LSB + SRC_W])
    else $error("unused bit set");

  chk_control_low: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    reg_ctl[NRDY_BIT-1:0] == 3'h0)
    else $error("unused control bit set");

  chk_pll_needs_lock: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !(i_pll_enabled && i_pll_locked) |-> !pll_ready)
    else $error("PLL ready without lock");

  chk_pll_needs_input: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    ((req_src_r == SRC_EXT_PLL) && !i_external_ready) |-> !pll_ready)
    else $error("PLL ready without input");

  chk_done_flag: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    reg_ctl[DONE_BIT] == (reg_req == reg_cur))
    else $error("complete flag wrong");

  chk_ready_flag: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    reg_ctl[NRDY_BIT] == (pending && src_ready))
    else $error("new ready flag wrong");

  chk_slow_ready: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (req_src_r == SRC_SLOW) |-> (src_ready == i_slow_internal_ready))
    else $error("slow source readiness");

  chk_pll_input: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (act_src_r == SRC_EXT_PLL) |-> o_pll_input_ext)
    else $error("PLL input not external");

  chk_read_current: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_rd && (i_addr == ADDR_CURRENT)) |=> o_rdata == $past(reg_cur))
    else $error("current read wrong");

  chk_read_idle: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !i_rd |=> o_rdata == 8'h00)
    else $error("read data without strobe");

  // Held switch, then hold released by software
  sequence s_held;
    hold_r && new_ready && !init_r;
  endsequence
  sequence s_freed;
    !hold_r && new_ready && !i_sleep && !wr_req;
  endsequence

  chk_release_switch: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    s_held ##1 s_freed |=> !pending)
    else $error("switch not done after release");
endmodule

// ### dv/osc_farside_model.sv
// Oscillators and PLL seen from the clock selector
`timescale 1ns/100ps
module osc_farside_model (
  input wire logic i_sys_clk,
  input wire logic [6:0] i_en,
  input wire logic [3:0] i_delay,
  output logic [6:0] o_ready,
  output logic [7:0] o_src_clk
);
  logic [3:0] wait_r [7] = '{default: 4'h0};
  logic [7:0] div_r = 8'h00;
  initial o_ready = 7'h00;
  // Ready only after a start-up delay, dropped at once when disabled
  always_ff @(posedge i_sys_clk) begin
    div_r <= div_r + 8'h01;
    for (int k = 0; k < 7; k++) begin
      wait_r[k] <= !i_en[k] ? 4'h0 : (wait_r[k] == i_delay) ? wait_r[k] : wait_r[k] + 4'h1;
      o_ready[k] <= i_en[k] && (wait_r[k] == i_delay);
    end
  end
  // Four rates from div_r bit g % 4, so sources four apart share a rate
  for (genvar g = 0; g < 8; g++) begin : g_clk
    assign o_src_clk[g] = div_r[g % 4];
  end
endmodule

// ### dv/oscillator_select_control_bench.sv
// Self-checking bench for the oscillator select control block
`timescale 1ns/100ps
module oscillator_select_control_bench;
  import osc_select_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [SRC_W-1:0] fuse = SRC_FAST;
  logic sw_en = 1'b1;
  logic sleep = 1'b0;
  logic clr = 1'b0;
  logic [6:0] en = 7'h7F;
  logic [3:0] dly = 4'h3;
  logic [6:0] rdy;
  logic [7:0] src_clk, rdata, d, cur, req;
  logic flag, hp, byp, pll_ext, sclk;
  logic [SRC_W-1:0] req_src;
  int num_errors = 0;
  int checks = 0;
  initial forever #2.5 clk = ~clk;
  osc_farside_model far (.i_sys_clk(clk), .i_en(en), .i_delay(dly), .o_ready(rdy),
    .o_src_clk(src_clk));
  oscillator_select_control DUT (.i_sys_clk(clk), .i_rst_n(rst_n), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_reset_source_fuse(fuse),
    .i_switch_enable_fuse(sw_en), .i_sleep(sleep), .i_src_clk(src_clk),
    .i_external_ready(rdy[0]), .i_fast_internal_ready(rdy[1]), .i_slow_internal_ready(rdy[2]),
    .i_secondary_ready(rdy[3]), .i_converter_rc_ready(rdy[4]), .i_pll_enabled(rdy[5]),
    .i_pll_locked(rdy[6]), .o_switch_interrupt_flag(flag), .i_switch_interrupt_clear(clr),
    .o_requested_source(req_src), .o_secondary_high_power(hp), .o_secondary_bypass(byp),
    .o_pll_input_ext(pll_ext), .o_sys_clk(sclk));
  task automatic step(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr_reg(logic [ADDR_W-1:0] a, logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(logic [ADDR_W-1:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic pulse_clr();
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask
  // Divided clock period in system cycles; long periods skipped to save run time
  task automatic chk_clk(logic [7:0] r);
    realtime t0;
    int p;
    p = 2 ** (r[6:4] % 4 + 1 + r[3:0]);
    if (p <= 64) begin
      @(posedge sclk);
      t0 = $realtime;
      @(posedge sclk);
      chk("clk period", 8'(p), 8'(int'(($realtime - t0) / 5.0)));
    end
  endtask
  function automatic logic [7:0] exp_req(logic [7:0] v);
    logic [2:0] s;
    logic [3:0] q;
    s = (v[6:4] == SRC_RSVD_HI || v[6:4] == SRC_RSVD_LO) ? SRC_FAST : v[6:4];
    q = (v[3:0] > DIV_MAX) ? DIV_MAX : v[3:0];
    return {1'b0, s, q};
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    step(40000);
    num_errors++;
    print_verdict();
  end
  initial begin
    logic [2:0] fl [6] = '{3'h7, 3'h6, 3'h4, 3'h3, 3'h1, 3'h0};
    logic [7:0] corner [3] = '{8'hD5, 8'h2F, 8'hFF};
    void'($urandom(8513));
    foreach (fl[i]) begin
      fuse <= fl[i];
      rst_n <= 1'b0;
      step(20);
      rst_n <= 1'b1;
      step(2);
      cur = {1'b0, fl[i], (fl[i] == SRC_FAST) ? DIV_RST_FAST : DIV_RST_OTHER};
      rd_reg(ADDR_REQUEST, d);
      chk("request", cur, d);
      rd_reg(ADDR_CURRENT, d);
      chk("current", cur, d);
      rd_reg(ADDR_CONTROL, d);
      chk("control", CTRL_RST, d & 8'hEF);
    end
    $display("reset test done");
    repeat (8) begin
      d = 8'($urandom);
      en <= {d[6:2], d[0], d[0]};
      step(24);
      rd_reg(ADDR_STATUS, req);
      chk("status", {d[0], d[0], 1'b0, d[2], d[3], d[4], 1'b0, &d[6:5] & d[0]}, req);
    end
    en <= 7'h7F;
    $display("status test done");
    for (int i = 0; i < 12; i++) begin
      d = (i < 3) ? corner[i] : 8'($urandom);
      dly <= 4'($urandom_range(0, 12));
      wr_reg(ADDR_REQUEST, d);
      step(30);
      req = exp_req(d);
      rd_reg(ADDR_REQUEST, d);
      chk("request", req, d);
      chk("req source", {5'h00, req[6:4]}, {5'h00, req_src});
      rd_reg(ADDR_CURRENT, d);
      chk("current", req, d);
      chk("pll input", {7'h00, req[6:4] == SRC_EXT_PLL}, {7'h00, pll_ext});
      chk_clk(req);
      rd_reg(ADDR_CONTROL, d);
      chk("control", 8'h10, d);
      chk("flag", {7'h00, req != cur}, {7'h00, flag});
      pulse_clr();
      step(1);
      chk("flag clear", 8'h00, {7'h00, flag});
      cur = req;
    end
    $display("switch test done");
    en <= 7'h00;
    req = (cur[6:4] == SRC_SLOW) ? 8'h70 : 8'h40;
    wr_reg(ADDR_REQUEST, req);
    step(10);
    rd_reg(ADDR_CONTROL, d);
    chk("pending", 8'h00, d);
    wr_reg(ADDR_CONTROL, 8'h80);
    en <= 7'h7F;
    step(30);
    rd_reg(ADDR_CONTROL, d);
    chk("held", 8'h88, d);
    rd_reg(ADDR_CURRENT, d);
    chk("old clock", cur, d);
    chk("held flag", 8'h01, {7'h00, flag});
    wr_reg(ADDR_CONTROL, 8'h00);
    step(10);
    rd_reg(ADDR_CONTROL, d);
    chk("released", 8'h10, d);
    rd_reg(ADDR_CURRENT, d);
    chk("new clock", req, d);
    chk_clk(req);
    cur = req;
    pulse_clr();
    en <= 7'h00;
    wr_reg(ADDR_CONTROL, 8'h80);
    wr_reg(ADDR_REQUEST, cur ^ 8'h01);
    sleep <= 1'b1;
    step(4);
    sleep <= 1'b0;
    rd_reg(ADDR_REQUEST, d);
    chk("abandon", cur, d);
    rd_reg(ADDR_CONTROL, d);
    chk("hold cleared", 8'h10, d);
    en <= 7'h7F;
    $display("hold and sleep test done");
    for (int v = 0; v < 4; v++) begin
      wr_reg(ADDR_CONTROL, {1'b0, v[1:0], 5'h1F});
      rd_reg(ADDR_CONTROL, d);
      chk("control", {1'b0, v[1:0], 5'h10}, d);
      chk("high power", {7'h00, v[1] & ~v[0]}, {7'h00, hp});
      chk("bypass", {7'h00, v[0]}, {7'h00, byp});
    end
    sw_en <= 1'b0;
    wr_reg(ADDR_REQUEST, cur ^ 8'h10);
    step(5);
    rd_reg(ADDR_REQUEST, d);
    chk("locked request", cur, d);
    $display("control and fuse test done");
    print_verdict();
  end
endmodule
